// ---- befc_defines.svh ----
// Offsets, word indices, reset values and timing constants of the burst and echo filter bank.
// Assumes it is included by bare name from each design file that needs these names.
`ifndef BEFC_DEFINES_SVH
`define BEFC_DEFINES_SVH

// Register offsets in the special-function register space.
`define BEFC_OFF_BP_B1_HI   8'h92
`define BEFC_OFF_BP_B1_LO   8'h93
`define BEFC_OFF_BP_A2_HI   8'h94
`define BEFC_OFF_BP_A2_LO   8'h95
`define BEFC_OFF_BP_A3_HI   8'h96
`define BEFC_OFF_BP_A3_LO   8'h97
`define BEFC_OFF_LP_B1_HI   8'hA1
`define BEFC_OFF_LP_B1_LO   8'hA2
`define BEFC_OFF_LP_A2_HI   8'hA3
`define BEFC_OFF_LP_A2_LO   8'hA4
`define BEFC_OFF_DECIM      8'hA5
`define BEFC_OFF_A_HIGH_HI  8'hA6
`define BEFC_OFF_A_HIGH_LO  8'hA7
`define BEFC_OFF_A_LOW_HI   8'hA9
`define BEFC_OFF_A_LOW_LO   8'hAA
`define BEFC_OFF_B_HIGH_HI  8'hAB
`define BEFC_OFF_B_HIGH_LO  8'hAC
`define BEFC_OFF_B_LOW_HI   8'hAD
`define BEFC_OFF_B_LOW_LO   8'hAE

// Storage layout: word n sits in bytes 2n (upper) and 2n+1 (lower).
`define BEFC_NREG           19
`define BEFC_W_BP_B1        0
`define BEFC_W_BP_A2        1
`define BEFC_W_BP_A3        2
`define BEFC_W_LP_B1        3
`define BEFC_W_LP_A2        4
`define BEFC_W_A_HIGH       5
`define BEFC_W_A_LOW        6
`define BEFC_W_B_HIGH       7
`define BEFC_W_B_LOW        8
`define BEFC_IX_DECIM       18

// Reset value of every register byte.
`define BEFC_RST_BYTE       8'h00

// Burst step of 62.5 ns against the 8 ns core clock, both in picoseconds.
`define BEFC_STEP_PS        17'd62500
`define BEFC_CLK_PERIOD_PS  17'd8000

`endif

// ---- befc_pkg.sv ----
// Types shared by the burst and echo filter bank.
// Assumes nothing of its surroundings; constants live in befc_defines.svh.
package befc_pkg;

  // Phase of one burst output channel.
  typedef enum logic [1:0] {
    BEFC_IDLE = 2'b00,
    BEFC_HIGH = 2'b01,
    BEFC_LOW  = 2'b10
  } befc_state_t;

endpackage

// ---- befc_iir.sv ----
// One IIR stage with up to two feedback taps, used for the bandpass and low-pass filters.
// Assumes samples arrive as single-cycle strobes with coefficients held stable between them.
`timescale 1ns/1ns
module befc_iir #(
  parameter int W      = 16,
  parameter int CW     = 16,
  parameter int FRAC   = 14,
  parameter bit SECOND = 1'b1
) (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  input  wire logic                 in_valid,
  input  wire logic signed [W-1:0]  in_data,
  input  wire logic signed [CW-1:0] b1,
  input  wire logic signed [CW-1:0] a2,
  input  wire logic signed [CW-1:0] a3,
  output logic                      out_valid,
  output logic signed [W-1:0]       out_data
);
  localparam int AW = CW + W + 3;

  logic signed [W-1:0]  x1_reg;
  logic signed [W-1:0]  x2_reg;
  logic signed [W-1:0]  y1_reg;
  logic signed [W-1:0]  y2_reg;
  logic signed [W:0]    sum;
  logic signed [AW-1:0] acc;
  logic signed [AW-1:0] shifted;
  logic signed [W-1:0]  y_next;

  // Second order forms b1*(x - x2) for a bandpass; first order forms b1*(x + x1) for a low-pass.
  // The result is truncated, not saturated, so coefficients must keep the loop gain in range.
  always_comb begin
    if (SECOND) begin
      sum = $signed({in_data[W-1], in_data}) - $signed({x2_reg[W-1], x2_reg});
    end else begin
      sum = $signed({in_data[W-1], in_data}) + $signed({x1_reg[W-1], x1_reg});
    end
    acc     = AW'(b1) * AW'(sum) - AW'(a2) * AW'(y1_reg) - AW'(a3) * AW'(y2_reg);
    shifted = acc >>> FRAC;
    y_next  = shifted[W-1:0];
  end

  // Delay line and output advance only on an input strobe.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      x1_reg    <= '0;
      x2_reg    <= '0;
      y1_reg    <= '0;
      y2_reg    <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        x2_reg   <= x1_reg;
        x1_reg   <= in_data;
        y2_reg   <= y1_reg;
        y1_reg   <= y_next;
        out_data <= y_next;
      end
    end
  end
endmodule

// ---- befc_top.sv ----
// Burst and echo filter configuration bank with its burst generator and echo filter chain.
// Assumes a processor SFR port with one-cycle write and read strobes, and a burst start pulse.
// Operation
// - Output A stays high for its high-duration count in 62.5 ns steps in each burst period.
// - Output A stays low for its low-duration count in 62.5 ns steps in each burst period.
// - Output B stays high for its high-duration count in 62.5 ns steps in each burst period.
// - Output B stays low for its low-duration count in 62.5 ns steps in each burst period.
// - The bandpass is a second-order IIR whose B1 word sets a bandwidth of 4 kHz to 7 kHz.
// - The bandpass A2 word places the centre frequency between 40 kHz and 70 kHz.
// - The bandpass A3 word works with B1 to set the bandwidth.
// - The low-pass is a first-order IIR using its B1 and A2 words, cut-off 0.5 to 4 kHz.
// - The dead time is cut from the end of each high duration in 62.5 ns steps.
// - Each burst issues the programmed number of pulses, 0 to 63, on output A.
`timescale 1ns/1ns
`include "befc_defines.svh"
module befc_top #(
  parameter int FRAC = 14
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        burst_start,
  input  wire logic [5:0]  first_pulse_total,
  input  wire logic [7:0]  deadtime,
  output logic             burst_busy,
  output logic             burst_output_first,
  output logic             burst_output_second,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        lowpass_enable,
  output logic             env_valid,
  output logic [15:0]      env_data
);
  localparam logic [7:0] OFFS [`BEFC_NREG] = '{
    `BEFC_OFF_BP_B1_HI, `BEFC_OFF_BP_B1_LO, `BEFC_OFF_BP_A2_HI, `BEFC_OFF_BP_A2_LO,
    `BEFC_OFF_BP_A3_HI, `BEFC_OFF_BP_A3_LO, `BEFC_OFF_LP_B1_HI, `BEFC_OFF_LP_B1_LO,
    `BEFC_OFF_LP_A2_HI, `BEFC_OFF_LP_A2_LO, `BEFC_OFF_A_HIGH_HI, `BEFC_OFF_A_HIGH_LO,
    `BEFC_OFF_A_LOW_HI, `BEFC_OFF_A_LOW_LO, `BEFC_OFF_B_HIGH_HI, `BEFC_OFF_B_HIGH_LO,
    `BEFC_OFF_B_LOW_HI, `BEFC_OFF_B_LOW_LO, `BEFC_OFF_DECIM
  };

  logic [7:0]  bank_reg [`BEFC_NREG];
  logic [4:0]  sel_ix;
  logic [7:0]  rdata_reg;
  logic [16:0] phase_reg;
  logic [16:0] phase_sum;
  logic        tick_reg;
  logic [15:0] on_w  [2];
  logic [15:0] off_w [2];
  logic [1:0]  drive_vec;
  logic [1:0]  busy_vec;
  logic [5:0]  total_reg;
  logic        start_pend_reg;
  logic [15:0] bandpass_feedforward_coeff;
  logic [15:0] bandpass_centre_coeff;
  logic [15:0] bandpass_width_coeff;
  logic [15:0] lowpass_feedforward_coeff;
  logic [15:0] lowpass_feedback_coeff;
  logic [7:0]  decim_ratio;
  logic        bpf_valid;
  logic [15:0] bpf_data;
  logic [15:0] bpf_mag;
  logic [7:0]  dec_cnt_reg;
  logic        dec_valid_reg;
  logic [15:0] dec_data_reg;
  logic        lpf_valid;
  logic [15:0] lpf_data;
  logic        env_valid_reg;
  logic [15:0] env_data_reg;
  // Sixteen-bit word built from its upper and lower byte registers.
  function automatic logic [15:0] word16(input int ix);
    return {bank_reg[2*ix], bank_reg[2*ix+1]};
  endfunction

  // Address decode against the fixed offset table; misses clear the hit flag and leave the index at zero.
  always_comb begin
    sfr_hit = 1'b0;
    sel_ix  = 5'h00;
    for (int i = 0; i < `BEFC_NREG; i++) begin
      if (sfr_addr == OFFS[i]) begin
        sfr_hit = 1'b1;
        sel_ix  = 5'(i);
      end
    end
  end

  // Byte-wide writes only; there is no bit-addressed path into this bank.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `BEFC_NREG; i++) begin
        bank_reg[i] <= `BEFC_RST_BYTE;
      end
    end else if (sfr_wr && sfr_hit) begin
      bank_reg[sel_ix] <= sfr_wdata;
    end
  end

  // Read data is registered on the read strobe; an unmapped address reads as zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      rdata_reg <= sfr_hit ? bank_reg[sel_ix] : 8'h00;
    end
  end
  assign sfr_rdata = rdata_reg;

  // Word assembly for the filter coefficients and burst durations.
  assign bandpass_feedforward_coeff = word16(`BEFC_W_BP_B1);
  assign bandpass_centre_coeff      = word16(`BEFC_W_BP_A2);
  assign bandpass_width_coeff       = word16(`BEFC_W_BP_A3);
  assign lowpass_feedforward_coeff  = word16(`BEFC_W_LP_B1);
  assign lowpass_feedback_coeff     = word16(`BEFC_W_LP_A2);
  assign decim_ratio                = bank_reg[`BEFC_IX_DECIM];
  assign on_w[0]  = word16(`BEFC_W_A_HIGH);
  assign off_w[0] = word16(`BEFC_W_A_LOW);
  assign on_w[1]  = word16(`BEFC_W_B_HIGH);
  assign off_w[1] = word16(`BEFC_W_B_LOW);

  // 62.5 ns is not a whole number of 8 ns cycles, so a phase accumulator spaces the
  // step enable 7 or 8 cycles apart; the average step is exact, single steps jitter by 8 ns.
  assign phase_sum = phase_reg + `BEFC_CLK_PERIOD_PS;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= 17'h00000;
      tick_reg  <= 1'b0;
    end else if (phase_sum >= `BEFC_STEP_PS) begin
      phase_reg <= phase_sum - `BEFC_STEP_PS;
      tick_reg  <= 1'b1;
    end else begin
      phase_reg <= phase_sum;
      tick_reg  <= 1'b0;
    end
  end

  // The pulse total is captured at start; the burst then waits for the next step enable
  // so that its first high phase is a whole number of steps, not a cut first step.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      total_reg      <= 6'h00;
      start_pend_reg <= 1'b0;
    end else if (burst_start && !burst_busy) begin
      total_reg      <= first_pulse_total;
      start_pend_reg <= (first_pulse_total != 6'h00);
    end else if (tick_reg) begin
      start_pend_reg <= 1'b0;
    end
  end

  // One channel per burst output; both run the same pulse total, each with its own timing.
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    befc_pkg::befc_state_t state_reg;
    logic [15:0] cnt_reg;
    logic [5:0]  pulses_reg;
    logic        drive_reg;
    logic [15:0] on_eff;
    logic        high_done;
    logic        low_done;

    // The dead time is taken off the end of the high phase, never below zero.
    assign on_eff    = (on_w[ch] > {8'h00, deadtime}) ? on_w[ch] - {8'h00, deadtime}
                                                      : 16'h0000;
    assign high_done = ({1'b0, cnt_reg} + 17'h00001) >= {1'b0, on_w[ch]};
    assign low_done  = ({1'b0, cnt_reg} + 17'h00001) >= {1'b0, off_w[ch]};

    // Phase sequencing: high for the high count, low for the low count, per pulse.
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        state_reg  <= befc_pkg::BEFC_IDLE;
        cnt_reg    <= 16'h0000;
        pulses_reg <= 6'h00;
      end else begin
        unique case (state_reg)
          befc_pkg::BEFC_IDLE: begin
            cnt_reg    <= 16'h0000;
            pulses_reg <= 6'h00;
            if (start_pend_reg && tick_reg) begin
              state_reg <= befc_pkg::BEFC_HIGH;
            end
          end
          befc_pkg::BEFC_HIGH: begin
            if (tick_reg) begin
              if (high_done) begin
                state_reg <= befc_pkg::BEFC_LOW;
                cnt_reg   <= 16'h0000;
              end else begin
                cnt_reg <= cnt_reg + 16'h0001;
              end
            end
          end
          befc_pkg::BEFC_LOW: begin
            if (tick_reg) begin
              if (low_done) begin
                cnt_reg    <= 16'h0000;
                pulses_reg <= pulses_reg + 6'h01;
                if (pulses_reg + 6'h01 >= total_reg) begin
                  state_reg <= befc_pkg::BEFC_IDLE;
                end else begin
                  state_reg <= befc_pkg::BEFC_HIGH;
                end
              end else begin
                cnt_reg <= cnt_reg + 16'h0001;
              end
            end
          end
          default: begin
            state_reg <= befc_pkg::BEFC_IDLE;
          end
        endcase
      end
    end

    // The pin follows the phase one cycle later, low during the trailing dead time.
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        drive_reg <= 1'b0;
      end else begin
        drive_reg <= (state_reg == befc_pkg::BEFC_HIGH) && (cnt_reg < on_eff);
      end
    end

    assign drive_vec[ch] = drive_reg;
    assign busy_vec[ch]  = (state_reg != befc_pkg::BEFC_IDLE);
  end

  assign burst_output_first  = drive_vec[0];
  assign burst_output_second = drive_vec[1];
  assign burst_busy          = (|busy_vec) | start_pend_reg;

  // Bandpass: b1*(x - x2) - a2*y1 - a3*y2, centre set by A2, width by B1 with A3.
  befc_iir #(
    .W      (16),
    .CW     (16),
    .FRAC   (FRAC),
    .SECOND (1'b1)
  ) u_bandpass (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .b1        (bandpass_feedforward_coeff),
    .a2        (bandpass_centre_coeff),
    .a3        (bandpass_width_coeff),
    .out_valid (bpf_valid),
    .out_data  (bpf_data)
  );

  // Rectify the bandpass output; the most negative value maps to itself.
  assign bpf_mag = bpf_data[15] ? 16'h0000 - bpf_data : bpf_data;

  // Keep one of every ratio samples; a ratio of zero behaves as one.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_cnt_reg   <= 8'h00;
      dec_valid_reg <= 1'b0;
      dec_data_reg  <= 16'h0000;
    end else begin
      dec_valid_reg <= 1'b0;
      if (bpf_valid) begin
        if (dec_cnt_reg + 8'h01 >= decim_ratio) begin
          dec_cnt_reg   <= 8'h00;
          dec_valid_reg <= 1'b1;
          dec_data_reg  <= bpf_mag;
        end else begin
          dec_cnt_reg <= dec_cnt_reg + 8'h01;
        end
      end
    end
  end

  // Low-pass: b1*(x + x1) - a2*y1 on the decimated envelope.
  befc_iir #(
    .W      (16),
    .CW     (16),
    .FRAC   (FRAC),
    .SECOND (1'b0)
  ) u_lowpass (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .in_valid  (dec_valid_reg),
    .in_data   (dec_data_reg),
    .b1        (lowpass_feedforward_coeff),
    .a2        (lowpass_feedback_coeff),
    .a3        (16'h0000),
    .out_valid (lpf_valid),
    .out_data  (lpf_data)
  );

  // Envelope output either after the low-pass or straight from the decimator.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      env_valid_reg <= 1'b0;
      env_data_reg  <= 16'h0000;
    end else if (lowpass_enable) begin
      env_valid_reg <= lpf_valid;
      env_data_reg  <= lpf_valid ? lpf_data : env_data_reg;
    end else begin
      env_valid_reg <= dec_valid_reg;
      env_data_reg  <= dec_valid_reg ? dec_data_reg : env_data_reg;
    end
  end
  assign env_valid = env_valid_reg;
  assign env_data  = env_data_reg;

  // Checks on the step enable, the burst phases and the register bank.
  sequence s_quiet6;
    (!tick_reg) [*6];
  endsequence
  property p_tick_spacing;
    @(posedge core_clk) disable iff (!arst_n)
      tick_reg |=> s_quiet6 ##[1:2] tick_reg;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("step spacing wrong");
  property p_a_low_phase;
    @(posedge core_clk) disable iff (!arst_n)
      $past(g_ch[0].state_reg) != befc_pkg::BEFC_HIGH |-> !burst_output_first;
  endproperty
  a_a_low_phase: assert property (p_a_low_phase) else $error("A high outside its phase");
  property p_b_low_phase;
    @(posedge core_clk) disable iff (!arst_n)
      $past(g_ch[1].state_reg) != befc_pkg::BEFC_HIGH |-> !burst_output_second;
  endproperty
  a_b_low_phase: assert property (p_b_low_phase) else $error("B high outside its phase");
  property p_a_high_hold;
    @(posedge core_clk) disable iff (!arst_n)
      g_ch[0].state_reg == befc_pkg::BEFC_HIGH && g_ch[0].cnt_reg < g_ch[0].on_eff
      |=> burst_output_first;
  endproperty
  a_a_high_hold: assert property (p_a_high_hold) else $error("A not high in phase");
  property p_b_high_hold;
    @(posedge core_clk) disable iff (!arst_n)
      g_ch[1].state_reg == befc_pkg::BEFC_HIGH && g_ch[1].cnt_reg < g_ch[1].on_eff
      |=> burst_output_second;
  endproperty
  a_b_high_hold: assert property (p_b_high_hold) else $error("B not high in phase");
  property p_dead_time;
    @(posedge core_clk) disable iff (!arst_n)
      g_ch[0].cnt_reg >= g_ch[0].on_eff |=> !burst_output_first;
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("A high in dead time");
  property p_pulse_limit;
    @(posedge core_clk) disable iff (!arst_n)
      g_ch[0].state_reg != befc_pkg::BEFC_IDLE |-> g_ch[0].pulses_reg < total_reg;
  endproperty
  a_pulse_limit: assert property (p_pulse_limit) else $error("pulse count overrun");
  property p_word_upper;
    @(posedge core_clk) disable iff (!arst_n)
      sfr_wr && sfr_addr == `BEFC_OFF_BP_B1_HI
      |=> bandpass_feedforward_coeff[15:8] == $past(sfr_wdata);
  endproperty
  a_word_upper: assert property (p_word_upper) else $error("upper byte not stored");
  property p_read_back;
    @(posedge core_clk) disable iff (!arst_n)
      sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00;
  endproperty
  a_read_back: assert property (p_read_back) else $error("unmapped read not zero");
endmodule

// ---- befc_top_tb.sv ----
// Self-checking bench for the burst and echo filter bank: registers, burst timing, filter path.
// Assumes befc_top with its SFR strobe port, a 125 MHz core clock and an active-low async reset.
`timescale 1ns/1ns
`include "befc_defines.svh"
module befc_top_tb;
  logic        core_clk;
  logic        arst_n;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        sfr_hit;
  logic        burst_start;
  logic [5:0]  first_pulse_total;
  logic [7:0]  deadtime;
  logic        burst_busy;
  logic        burst_output_first;
  logic        burst_output_second;
  logic        sample_valid;
  logic [15:0] sample_data;
  logic        lowpass_enable;
  logic        env_valid;
  logic [15:0] env_data;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  int          smp_q[$];
  int          env_q[$];
  logic [15:0] envd_q[$];
  logic [7:0]  shadow [19];
  logic [7:0]  offs [19] = '{`BEFC_OFF_BP_B1_HI, `BEFC_OFF_BP_B1_LO, `BEFC_OFF_BP_A2_HI,
    `BEFC_OFF_BP_A2_LO, `BEFC_OFF_BP_A3_HI, `BEFC_OFF_BP_A3_LO, `BEFC_OFF_LP_B1_HI,
    `BEFC_OFF_LP_B1_LO, `BEFC_OFF_LP_A2_HI, `BEFC_OFF_LP_A2_LO, `BEFC_OFF_A_HIGH_HI,
    `BEFC_OFF_A_HIGH_LO, `BEFC_OFF_A_LOW_HI, `BEFC_OFF_A_LOW_LO, `BEFC_OFF_B_HIGH_HI,
    `BEFC_OFF_B_HIGH_LO, `BEFC_OFF_B_LOW_HI, `BEFC_OFF_B_LOW_LO, `BEFC_OFF_DECIM};

  befc_top i_befc_top (
    .core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .burst_start(burst_start), .first_pulse_total(first_pulse_total), .deadtime(deadtime),
    .burst_busy(burst_busy), .burst_output_first(burst_output_first),
    .burst_output_second(burst_output_second), .sample_valid(sample_valid),
    .sample_data(sample_data), .lowpass_enable(lowpass_enable), .env_valid(env_valid),
    .env_data(env_data)
  );

  // Free-running 8 ns clock.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Cycle count with a hang ceiling, plus capture of sample and envelope strobes.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (sample_valid === 1'b1) smp_q.push_back(cyc);
    if (env_valid === 1'b1) begin
      env_q.push_back(cyc);
      envd_q.push_back(env_data);
    end
    if (cyc == 60000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Cycles of 8 ns nearest to a count of 62.5 ns steps; the design dithers 7 and 8 cycles.
  function automatic int exp_cyc(input int steps);
    return (steps * 62500 + 4000) / 8000;
  endfunction

  // A run length is accepted within two cycles, which covers the dither and output lag.
  function automatic logic near(input int seen, input int steps);
    int e;
    e = exp_cyc(steps);
    return (seen >= e - 2) && (seen <= e + 2);
  endfunction

  // Bandpass output with B1 at unity and both feedback taps zero is x minus x two back.
  function automatic logic [15:0] exp_env(input int x0, input int x2);
    int y;
    y = x0 - x2;
    return 16'(y < 0 ? -y : y);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    d = sfr_rdata;
    h = sfr_hit;
  endtask

  // Word n is written as its upper byte register and then its lower byte register.
  task automatic wr16(input int w, input logic [15:0] v);
    wr(offs[2*w], v[15:8]);
    wr(offs[2*w+1], v[7:0]);
  endtask

  task automatic send(input logic [15:0] v);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample_data  <= v;
    @(posedge core_clk);
    sample_valid <= 1'b0;
  endtask

  // One burst: B runs one step longer high than A; a second start mid-burst must be ignored.
  task automatic burst(input int on, input int off, input int dead, input int tot);
    int         n[2];
    int         run[2];
    int         low[2];
    int         t;
    int         offx;
    logic [1:0] o;
    logic [1:0] prev;
    n = '{0, 0};
    run = '{0, 0};
    low = '{0, 0};
    prev = 2'b00;
    t = 0;
    offx = (off > 0) ? off : 1;
    wr16(`BEFC_W_A_HIGH, 16'(on));
    wr16(`BEFC_W_A_LOW, 16'(off));
    wr16(`BEFC_W_B_HIGH, 16'(on + 1));
    wr16(`BEFC_W_B_LOW, 16'(off));
    deadtime          <= 8'(dead);
    first_pulse_total <= 6'(tot);
    @(posedge core_clk);
    burst_start <= 1'b1;
    @(posedge core_clk);
    burst_start <= 1'b0;
    while (t < 20000) begin
      @(posedge core_clk);
      burst_start <= (t == 5);
      #1;
      t++;
      o = {burst_output_second, burst_output_first};
      for (int c = 0; c < 2; c++) begin
        if (o[c] === 1'b1 && prev[c] === 1'b0 && n[c] > 0)
          check("low_len", near(low[c], offx + dead), 1);
        if (o[c] === 1'b1) begin
          run[c]++;
        end else if (prev[c] === 1'b1) begin
          n[c]++;
          check("high_len", near(run[c], on + c - dead), 1);
          run[c] = 0;
          low[c] = 1;
        end else begin
          low[c]++;
        end
      end
      prev = o;
      if (burst_busy !== 1'b1) break;
    end
    check("burst_ends", t < 20000, 1);
    check("pulses_a", n[0], tot);
    check("pulses_b", n[1], tot);
  endtask

  initial begin
    logic [7:0] d;
    logic       h;
    int         x[12];
    int         found;
    int         on;
    arst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    burst_start = 1'b0;
    first_pulse_total = 6'h00;
    deadtime = 8'h00;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    lowpass_enable = 1'b0;
    void'($urandom(32'hD3B63810));
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    // Reset values, random write and read-back, then an unmapped hole between offsets.
    for (int i = 0; i < 19; i++) begin
      rd(offs[i], d, h);
      check("reset_value", d, `BEFC_RST_BYTE);
      check("hit", h, 1'b1);
      shadow[i] = 8'($urandom);
      wr(offs[i], shadow[i]);
    end
    wr(8'hA8, 8'h5A);
    for (int i = 0; i < 19; i++) begin
      rd(offs[i], d, h);
      check("readback", d, shadow[i]);
    end
    rd(8'hA8, d, h);
    check("unmapped_data", d, 8'h00);
    check("unmapped_hit", h, 1'b0);
    // Bandpass path in bypass with ratio one: every random sample yields one envelope value.
    wr16(`BEFC_W_BP_B1, 16'h4000);
    wr16(`BEFC_W_BP_A2, 16'h0000);
    wr16(`BEFC_W_BP_A3, 16'h0000);
    wr(offs[`BEFC_IX_DECIM], 8'h01);
    smp_q.delete();
    env_q.delete();
    envd_q.delete();
    for (int i = 0; i < 12; i++) begin
      x[i] = int'($urandom_range(2000)) - 1000;
      send(16'(x[i]));
    end
    repeat (8) @(posedge core_clk);
    check("env_count", env_q.size(), 12);
    for (int i = 0; i < env_q.size() && i < 12; i++) begin
      check("env_lat", env_q[i] - smp_q[i], 3);
      check("env_data", envd_q[i], exp_env(x[i], i > 1 ? x[i-2] : 0));
    end
    // Low-pass path with ratio 25: fifty samples give two outputs, four cycles after a sample.
    wr16(`BEFC_W_LP_B1, 16'h2000);
    wr16(`BEFC_W_LP_A2, 16'h0000);
    wr(offs[`BEFC_IX_DECIM], 8'h19);
    lowpass_enable <= 1'b1;
    smp_q.delete();
    env_q.delete();
    for (int i = 0; i < 50; i++) send(16'($urandom_range(1000)));
    repeat (10) @(posedge core_clk);
    check("lp_count", env_q.size(), 2);
    foreach (env_q[k]) begin
      found = 0;
      foreach (smp_q[j]) if (smp_q[j] == env_q[k] - 4) found = 1;
      check("lp_lat", found, 1);
    end
    // Bursts: square wave at 2 MHz, a zero low count, a wide word, no pulses, then random ones.
    burst(16000 / 2000 / 2, 16000 / 2000 / 2, 1, 3);
    burst(1, 0, 0, 2);
    burst(16'h0101, 3, 5, 2);
    burst(4, 4, 0, 0);
    for (int r = 0; r < 4; r++) begin
      on = 2 + int'($urandom_range(9));
      burst(on, int'($urandom_range(9)), int'($urandom_range(on - 1)), 1 + $urandom_range(3));
    end
    stop_test();
  end
endmodule
